// File: fine_pwm_pkg.sv
// Constants shared by the fine PWM timer channel
package fine_pwm_pkg;
   // Register byte offsets
   localparam logic [7:0]  REG_CHANNEL_CONTROL = 8'h00;
   localparam logic [7:0]  REG_RISE_COMPARE    = 8'h04;
   localparam logic [7:0]  REG_PERIOD_COMPARE  = 8'h08;
   localparam logic [7:0]  REG_PRESCALER       = 8'h0C;
   localparam logic [7:0]  REG_PIN_FUNCTION    = 8'h10;
   localparam logic [7:0]  REG_STATUS          = 8'h14;
   localparam logic [7:0]  REG_ACTIVE_RISE     = 8'h18;
   // Channel control bit positions
   localparam int          CC_RUN_CONTROL      = 0;
   localparam int          CC_COUNTER_PRESET   = 1;
   localparam int          CC_TIMER_OUTPUT_ON  = 2;
   localparam int          CC_CLOCK_SOURCE     = 3;
   localparam int          CC_POLARITY         = 4;
   localparam int          CC_BUFFER_ENABLE    = 5;
   localparam int          CC_FINE_MODE        = 6;
   // Prescaler register fields
   localparam int          PS_CLOCK_ON         = 0;
   localparam int          PS_DIVIDE_LSB       = 1;
   // Status register fields
   localparam int          ST_LEVEL            = 16;
   localparam int          ST_FIFO_LSB         = 17;
   localparam int          ST_FIFO_FULL        = 21;
   localparam int          ST_FIFO_EMPTY       = 22;
   localparam int          ST_PIN_IN           = 23;
   // Widths, depths and reset values
   localparam int          CNT_W               = 16;
   localparam int          DIV_W               = 3;
   localparam int          PRE_W               = 7;
   localparam int          FIFO_DEPTH          = 8;
   localparam int          FIFO_LVL_W          = 4;
   localparam logic [6:0]  CTRL_RESET          = 7'h00;
   localparam logic [15:0] CMP_RESET           = 16'h0000;
   localparam logic [15:0] PERIOD_RESET        = 16'hFFFF;
   localparam logic [3:0]  PRESC_RESET         = 4'h0;
   // Clock figures
   localparam int          CLK_MHZ             = 40;
   localparam int          FINE_EQUIV_MHZ      = 2 * CLK_MHZ;
endpackage : fine_pwm_pkg

// File: fine_pwm_timer_channel.sv
// Fine PWM timer channel: Wishbone slave, sample FIFO and PWM engine
//
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
module fine_pwm_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8,
   parameter int LVL_W = 4
) (
   // Clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_sys_rst,
   input  wire logic             i_clk_en,
   // Fill side
   input  wire logic             i_push_valid,
   output logic                  o_push_ready,
   input  wire logic [WIDTH-1:0] i_push_data,
   // Drain side
   output logic                  o_pop_valid,
   input  wire logic             i_pop_ready,
   output logic      [WIDTH-1:0] o_pop_data,
   output logic      [LVL_W-1:0] o_level
);
   localparam int                 IDX_W = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [IDX_W-1:0] wr_q;
   logic [IDX_W-1:0] rd_q;
   logic [LVL_W-1:0] lvl_q;
   logic             push;
   logic             pop;

   assign o_push_ready = (lvl_q != LVL_W'(DEPTH));
   assign o_pop_valid  = (lvl_q != '0);
   assign o_pop_data   = mem_q[rd_q];
   assign o_level      = lvl_q;
   assign push         = i_push_valid && o_push_ready;
   assign pop          = i_pop_ready && o_pop_valid;

   always_ff @(posedge i_clk) begin
      if (i_clk_en && push) begin
         mem_q[wr_q] <= i_push_data;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         lvl_q <= '0;
      end else if (i_clk_en) begin
         if (push) begin
            wr_q <= (wr_q == IDX_W'(DEPTH - 1)) ? '0 : IDX_W'(wr_q + 1'b1);
         end
         if (pop) begin
            rd_q <= (rd_q == IDX_W'(DEPTH - 1)) ? '0 : IDX_W'(rd_q + 1'b1);
         end
         if (push && !pop) begin
            lvl_q <= LVL_W'(lvl_q + 1'b1);
         end else if (pop && !push) begin
            lvl_q <= LVL_W'(lvl_q - 1'b1);
         end
      end
   end
endmodule : fine_pwm_fifo

module fine_pwm_timer_channel
   import fine_pwm_pkg::*;
(
   // Clock, enable, reset
   input  wire logic        i_clk,
   input  wire logic        i_clk_en,
   input  wire logic        i_sys_rst,
   // Wishbone slave
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [7:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic             o_wb_ack,
   output logic      [31:0] o_wb_dat,
   // External count source
   input  wire logic        i_ext_count_en,
   // Shared pin and general I/O port
   input  wire logic        i_gpio_out,
   input  wire logic        i_gpio_oe,
   input  wire logic        i_pin_i,
   output logic      [1:0]  o_pin_o,
   output logic             o_pin_oe
);
   logic [6:0]        ctrl_q;
   logic [CNT_W-1:0]  period_q;
   logic [CNT_W-1:0]  rise_act_q;
   logic [3:0]        presc_q;
   logic              pin_sel_q;
   logic [PRE_W-1:0]  pre_cnt_q;
   logic [CNT_W-1:0]  cnt_q;
   logic              raw_q;
   logic [1:0]        ddr_q;
   logic              ack_q;
   logic [31:0]       rdat_q;
   logic              req;
   logic              wr_fire;
   logic              hold;
   logic              tick_int;
   logic              tick;
   logic              run_tick;
   logic              rise_match;
   logic              end_match;
   logic              rise_half;
   logic              end_half;
   logic              fifo_ready;
   logic              fifo_valid;
   logic [CNT_W-1:0]  fifo_data;
   logic [FIFO_LVL_W-1:0] fifo_lvl;
   logic              push_v;
   logic              pop_r;
   logic [1:0]        pwm_lvl;
   logic [31:0]       rd_mux;

   wire run_q   = ctrl_q[CC_RUN_CONTROL];
   wire out_on  = ctrl_q[CC_TIMER_OUTPUT_ON];
   wire int_src = ctrl_q[CC_CLOCK_SOURCE];
   wire inv_q   = ctrl_q[CC_POLARITY];
   wire buf_en  = ctrl_q[CC_BUFFER_ENABLE];
   wire fine_q  = ctrl_q[CC_FINE_MODE];

   // Compare position in whole clocks; fine mode counts half clocks
   function automatic logic [CNT_W-1:0] cmp_pos(input logic [CNT_W-1:0] v, input logic f);
      cmp_pos = f ? {1'b0, v[CNT_W-1:1]} : v;
   endfunction : cmp_pos

   function automatic logic [PRE_W-1:0] div_mask(input logic [DIV_W-1:0] s);
      div_mask = PRE_W'((8'h01 << s) - 8'h01);
   endfunction : div_mask

   // Bus: one wait cycle; a rise write in buffered mode waits for FIFO room
   assign req     = i_wb_cyc && i_wb_stb;
   assign hold    = i_wb_we && (i_wb_adr == REG_RISE_COMPARE) && buf_en && !fifo_ready;
   assign wr_fire = req && i_wb_we && ack_q && i_wb_sel[0];
   assign o_wb_ack = ack_q;
   assign o_wb_dat = rdat_q;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         ack_q <= 1'b0;
      end else if (i_clk_en) begin
         ack_q <= req && !ack_q && !hold;
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (i_wb_adr)
         REG_CHANNEL_CONTROL: rd_mux = {25'h0, ctrl_q};
         REG_PERIOD_COMPARE:  rd_mux = {16'h0, period_q};
         REG_PRESCALER:       rd_mux = {28'h0, presc_q};
         REG_PIN_FUNCTION:    rd_mux = {31'h0, pin_sel_q};
         REG_STATUS:          rd_mux = {8'h00, i_pin_i, !fifo_valid, !fifo_ready,
                                        fifo_lvl, raw_q, cnt_q};
         REG_ACTIVE_RISE:     rd_mux = {16'h0, rise_act_q};
         default:             rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         rdat_q <= 32'h0000_0000;
      end else if (i_clk_en && req && !ack_q) begin
         rdat_q <= rd_mux;
      end
   end

   // Configuration registers
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         ctrl_q    <= CTRL_RESET;
         period_q  <= PERIOD_RESET;
         presc_q   <= PRESC_RESET;
         pin_sel_q <= 1'b0;
      end else if (i_clk_en && wr_fire) begin
         case (i_wb_adr)
            REG_CHANNEL_CONTROL: ctrl_q <= i_wb_dat[6:0] & 7'h7D; // preset never stored
            REG_PERIOD_COMPARE: begin
               if (i_wb_sel[1]) begin
                  period_q <= i_wb_dat[15:0];
               end
            end
            REG_PRESCALER:       presc_q <= i_wb_dat[3:0];
            REG_PIN_FUNCTION:    pin_sel_q <= i_wb_dat[0];
            default: begin
            end
         endcase
      end
   end

   // Prescaler: divide select 0 passes every clock
   assign tick_int = presc_q[PS_CLOCK_ON] &&
                     ((pre_cnt_q & div_mask(presc_q[PS_DIVIDE_LSB +: DIV_W])) ==
                      div_mask(presc_q[PS_DIVIDE_LSB +: DIV_W]));
   assign tick     = int_src ? tick_int : i_ext_count_en;
   assign run_tick = run_q && tick;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         pre_cnt_q <= '0;
      end else if (i_clk_en) begin
         pre_cnt_q <= presc_q[PS_CLOCK_ON] ? PRE_W'(pre_cnt_q + 1'b1) : '0;
      end
   end

   // Sample FIFO: back-pressure stalls the bus ack
   assign push_v = wr_fire && (i_wb_adr == REG_RISE_COMPARE) && buf_en && i_wb_sel[1];
   assign pop_r  = buf_en && (!run_q || (run_tick && end_match));

   fine_pwm_fifo #(
      .WIDTH (CNT_W),
      .DEPTH (FIFO_DEPTH),
      .LVL_W (FIFO_LVL_W)
   ) u_fifo (
      .i_clk        (i_clk),
      .i_sys_rst    (i_sys_rst),
      .i_clk_en     (i_clk_en),
      .i_push_valid (push_v),
      .o_push_ready (fifo_ready),
      .i_push_data  (i_wb_dat[15:0]),
      .o_pop_valid  (fifo_valid),
      .i_pop_ready  (pop_r),
      .o_pop_data   (fifo_data),
      .o_level      (fifo_lvl)
   );

   // Active rise compare
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         rise_act_q <= CMP_RESET;
      end else if (i_clk_en) begin
         if (!buf_en && wr_fire && (i_wb_adr == REG_RISE_COMPARE) && i_wb_sel[1]) begin
            rise_act_q <= i_wb_dat[15:0];
         end else if (pop_r && fifo_valid) begin
            rise_act_q <= fifo_data;
         end
         // Otherwise held, so each cycle repeats
      end
   end

   // Counter and edge placement
   assign rise_match = (cnt_q == cmp_pos(rise_act_q, fine_q));
   assign end_match  = (cnt_q == cmp_pos(period_q, fine_q));
   assign rise_half  = fine_q && rise_act_q[0];
   assign end_half   = fine_q && period_q[0];

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         cnt_q <= '0;
      end else if (i_clk_en) begin
         if (wr_fire && (i_wb_adr == REG_CHANNEL_CONTROL) && i_wb_dat[CC_COUNTER_PRESET]) begin
            cnt_q <= '0;
         end else if (run_tick) begin
            cnt_q <= end_match ? '0 : CNT_W'(cnt_q + 1'b1);
         end
      end
   end

   // ddr_q[0] is the first half clock, ddr_q[1] the second
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         raw_q <= 1'b0;
         ddr_q <= 2'b00;
      end else if (i_clk_en) begin
         if (!run_q) begin
            raw_q <= 1'b0;
            ddr_q <= 2'b00;
         end else if (run_tick && end_match) begin
            // Fall wins over a rise at the same count
            raw_q <= 1'b0;
            ddr_q <= {1'b0, end_half ? (raw_q || (rise_match && !rise_half)) : 1'b0};
         end else if (run_tick && rise_match) begin
            raw_q <= 1'b1;
            ddr_q <= {1'b1, rise_half ? raw_q : 1'b1};
         end else begin
            ddr_q <= {raw_q, raw_q};
         end
      end
   end

   // Pin mux: output stage mixes the two halves at twice the clock rate
   assign pwm_lvl  = out_on ? (ddr_q ^ {2{inv_q}}) : {2{inv_q}};
   assign o_pin_o  = pin_sel_q ? pwm_lvl : {2{i_gpio_out}};
   assign o_pin_oe = pin_sel_q ? out_on : i_gpio_oe;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   AST_START_LOW: assert property ((i_clk_en && !run_q) |=> !raw_q)
      else $error("Output not low while stopped");
   AST_RISE_HIGH: assert property (
      (i_clk_en && run_tick && rise_match && !end_match && !fine_q) |=> raw_q && ddr_q == 2'b11)
      else $error("Rise match did not drive high");
   AST_PERIOD_END: assert property (
      (i_clk_en && run_tick && end_match) |=> (cnt_q == '0 && !raw_q && !ddr_q[1]))
      else $error("Period match did not end cycle");
   AST_MIDCYCLE_HOLD: assert property (
      (i_clk_en && run_q && !end_match && buf_en) |=> $stable(rise_act_q))
      else $error("Active rise changed mid cycle");
   AST_FINE_HALF: assert property (
      (i_clk_en && run_tick && fine_q && rise_match && rise_act_q[0] && !raw_q && !end_match)
      |=> ddr_q == 2'b10)
      else $error("Half clock rise misplaced");
   AST_OUT_OFF: assert property ((pin_sel_q && !out_on) |-> o_pin_o == {2{inv_q}})
      else $error("Output driven while off");
   AST_PIN_GPIO: assert property (!pin_sel_q |-> o_pin_o == {2{i_gpio_out}}
      && o_pin_oe == i_gpio_oe) else $error("Pin not released to port");
   AST_DIV_ONE: assert property (
      (presc_q[PS_CLOCK_ON] && presc_q[PS_DIVIDE_LSB +: DIV_W] == '0) |-> tick_int)
      else $error("Divide by one skipped a clock");
   AST_RELOAD: assert property (
      (i_clk_en && buf_en && run_tick && end_match && fifo_valid) |=>
      rise_act_q == $past(fifo_data)) else $error("Pending rise not loaded");
   AST_ACK_ONE: assert property ((i_clk_en && o_wb_ack) |=> !o_wb_ack)
      else $error("Ack held two cycles");

   COV_CYCLE_END: cover property (run_tick && end_match && raw_q);
   COV_FIFO_FULL: cover property (buf_en && !fifo_ready && req && hold);
   COV_FINE_EDGE: cover property (run_tick && fine_q && rise_match && rise_act_q[0]);
endmodule : fine_pwm_timer_channel

// File: fine_pwm_timer_channel_bench.sv
// Self-checking bench for the fine PWM timer channel
module fine_pwm_timer_channel_bench
   import fine_pwm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk;
   logic        clk_en;
   logic        rst;
   logic        cyc;
   logic        stb;
   logic        wen;
   logic [7:0]  adr;
   logic [31:0] wdat;
   logic        ack;
   logic [31:0] rdat;
   logic        ext_en;
   logic        gpio_out;
   logic        gpio_oe;
   logic        pin_i;
   logic [1:0]  pin_o;
   logic        pin_oe;
   logic        lvl = 1'b0;
   int          err_count;
   int          checks_done;
   int          per_len;
   int          hi_len;
   int          per_c;
   int          hi_c;
   int          rises;

   fine_pwm_timer_channel i_fine_pwm_timer_channel (
      .i_clk          (clk),
      .i_clk_en       (clk_en),
      .i_sys_rst      (rst),
      .i_wb_cyc       (cyc),
      .i_wb_stb       (stb),
      .i_wb_we        (wen),
      .i_wb_adr       (adr),
      .i_wb_sel       (4'hF),
      .i_wb_dat       (wdat),
      .o_wb_ack       (ack),
      .o_wb_dat       (rdat),
      .i_ext_count_en (ext_en),
      .i_gpio_out     (gpio_out),
      .i_gpio_oe      (gpio_oe),
      .i_pin_i        (pin_i),
      .o_pin_o        (pin_o),
      .o_pin_oe       (pin_oe)
   );

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Pin measured in half clocks, sampled on the falling edge where it is settled
   always @(negedge clk) begin
      for (int h = 0; h < 2; h++) begin
         if (pin_o[h] === 1'b1 && lvl === 1'b0) begin
            per_len = per_c;
            per_c = 0;
            hi_c = 0;
            rises++;
         end
         if (pin_o[h] !== 1'b1 && lvl === 1'b1) begin
            hi_len = hi_c;
         end
         per_c++;
         if (pin_o[h] === 1'b1) begin
            hi_c++;
         end
         lvl = (pin_o[h] === 1'b1);
      end
   end

   task automatic complete_run();
      $display("mismatches %0d comparisons %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : complete_run

   task automatic check(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         err_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask : check

   // Classic cycle: hold everything until ack is sampled, wait is bounded
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output int n);
      n = 0;
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      wen  <= w;
      adr  <= a;
      wdat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20000);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 20000) begin
         err_count++;
         complete_run();
      end
   endtask : wb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      int          n;
      wb(1'b1, a, d, q, n);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      int n;
      wb(1'b0, a, 32'h0, q, n);
   endtask : rd

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      rd(a, q);
      check(q, e);
   endtask : rdchk

   task automatic wait_rises(input int k);
      int s;
      int t;
      s = rises;
      t = 0;
      while (rises < s + k && t < 20000) begin
         @(posedge clk);
         t++;
      end
      if (t >= 20000) begin
         err_count++;
         complete_run();
      end
   endtask : wait_rises

   task automatic meas(input logic [31:0] ep, input logic [31:0] eh);
      wait_rises(3);
      check(32'(per_len), ep);
      check(32'(hi_len), eh);
   endtask : meas

   task automatic cnt_moves(input logic e);
      logic [31:0] q1;
      logic [31:0] q2;
      rd(REG_STATUS, q1);
      rd(REG_STATUS, q2);
      check({31'h0, q1[15:0] !== q2[15:0]}, {31'h0, e});
   endtask : cnt_moves

   // Stop first so an unbuffered rise write lands in the active compare
   task automatic cfg(input logic [31:0] c, input logic [31:0] r, input logic [31:0] p,
                      input logic [31:0] ps);
      wr(REG_CHANNEL_CONTROL, 32'h0);
      wr(REG_PRESCALER, ps);
      wr(REG_PIN_FUNCTION, 32'h1);
      wr(REG_PERIOD_COMPARE, p);
      wr(REG_RISE_COMPARE, r);
      wr(REG_CHANNEL_CONTROL, c);
   endtask : cfg

   initial begin
      logic [31:0] q;
      logic [31:0] q2;
      int          n;
      {rst, cyc, stb, wen, adr, wdat, ext_en, pin_i} = '0;
      {gpio_out, gpio_oe, clk_en} = 3'b111;
      {err_count, checks_done} = '0;
      rst = 1'b1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rdchk(REG_CHANNEL_CONTROL, 32'h0);
      rdchk(REG_PERIOD_COMPARE, 32'h0000FFFF);
      rdchk(REG_PRESCALER, 32'h0);
      rdchk(REG_STATUS, 32'h00400000);
      rdchk(8'h1C, 32'h0);
      check({29'h0, pin_oe, pin_o}, 32'h7);
      wr(REG_PERIOD_COMPARE, 32'h1234ABCD);
      rdchk(REG_PERIOD_COMPARE, 32'h0000ABCD);
      wr(REG_RISE_COMPARE, 32'h0000BEEF);
      rdchk(REG_RISE_COMPARE, 32'h0);
      rdchk(REG_ACTIVE_RISE, 32'h0000BEEF);
      // Internal clock, output on, preset and run
      cfg(32'h0F, 32'h14, 32'h63, 32'h1);
      repeat (3) @(posedge clk);
      @(negedge clk);
      check({30'h0, pin_o}, 32'h0);
      rdchk(REG_CHANNEL_CONTROL, 32'h0D);
      meas(32'd200, 32'd158);
      meas(32'd200, 32'd158);
      cfg(32'h1F, 32'h14, 32'h63, 32'h1);
      meas(32'd200, 32'd42);
      cfg(32'h0F, 32'h14, 32'h63, 32'h3);
      meas(32'd400, 32'd316);
      cfg(32'h0F, 32'h14, 32'h63, 32'h0);
      cnt_moves(1'b0);
      cfg(32'h07, 32'h14, 32'h63, 32'h1);
      cnt_moves(1'b0);
      ext_en <= 1'b1;
      cnt_moves(1'b1);
      // Enable low freezes the count: only the three live edges between the reads count
      rd(REG_STATUS, q);
      clk_en <= 1'b0;
      repeat (20) @(posedge clk);
      clk_en <= 1'b1;
      rd(REG_STATUS, q2);
      check(32'((q2[15:0] + 16'd100 - q[15:0]) % 16'd100), 32'd3);
      cfg(32'h4F, 32'h5, 32'h15, 32'h1);
      meas(32'd22, 32'd16);
      cfg(32'h0B, 32'h14, 32'h63, 32'h1);
      repeat (3) @(posedge clk);
      @(negedge clk);
      check({29'h0, pin_oe, pin_o}, 32'h0);
      wr(REG_PIN_FUNCTION, 32'h0);
      gpio_out <= 1'b0;
      pin_i    <= 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk);
      check({29'h0, pin_oe, pin_o}, 32'h4);
      rd(REG_STATUS, q);
      check({31'h0, q[ST_PIN_IN]}, 32'h1);
      // Buffered rewrite in the high part of a cycle
      cfg(32'h2F, 32'h14, 32'h63, 32'h1);
      wait_rises(2);
      wr(REG_RISE_COMPARE, 32'h32);
      rdchk(REG_ACTIVE_RISE, 32'h14);
      wait_rises(1);
      check(32'(hi_len), 32'd158);
      wait_rises(1);
      check(32'(hi_len), 32'd98);
      // Audio-like carrier; far side pops one word per cycle end
      cfg(32'h2F, 32'h10, 32'h1F3, 32'h1);
      wait_rises(1);
      for (int i = 0; i < FIFO_DEPTH; i++) begin
         wr(REG_RISE_COMPARE, 32'h64 + 32'(i));
      end
      rd(REG_STATUS, q);
      check({27'h0, q[ST_FIFO_FULL], q[ST_FIFO_LSB +: FIFO_LVL_W]}, 32'h18);
      wb(1'b1, REG_RISE_COMPARE, 32'h6C, q, n);
      check({31'h0, n > 20}, 32'h1);
      rdchk(REG_ACTIVE_RISE, 32'h64);
      wr(REG_CHANNEL_CONTROL, 32'h2C);
      n = 0;
      q = '0;
      while (q[ST_FIFO_EMPTY] !== 1'b1 && n < 50) begin
         rd(REG_STATUS, q);
         n++;
      end
      check({31'h0, q[ST_FIFO_EMPTY]}, 32'h1);
      rdchk(REG_ACTIVE_RISE, 32'h6C);
      complete_run();
   end
endmodule : fine_pwm_timer_channel_bench
